// File: design/hot_plug_status_function_regs.sv
// Status and function registers of a dual-slot hot plug controller with its serial target.
//
// Overview of operation
// - Slot status: fault mirror, enables, three flags.
// - Mirror reads one while any flag is set and the slot is in direct mode.
// - Fault held until enable cycles, plus echo.
// - Force-on low releases fault pin and main rails.
// - Mirror inactive under serial bus control.
// - Enable bits show internally enabled rails.
// - Standby flag: overcurrent with timer or stage one.
// - Rail flags: timer, stage one or fast trip.
// - Writing one, then a read, clears flag; interrupt releases.
// - Shared status: inputs, mask, undervoltage, overtemperature.
// - General inputs reported after deglitch interval.
// - Mask high keeps interrupt inactive.
// - Undervoltage flag follows main rails only.
// - Overtemperature flag follows stage two shutdown.
// - Function register fields, resets to 0dh.
// - Function register never reads zero.
// - Standby high mode is strap OR select.
// - Discharged flag when all slot outputs low.
// - Main limit enable keeps normal limiting.
// - Echoed flag clears on next read.
// - Reserved bits read zero.
// - Target address fixed upper, strapped lower.
`default_nettype none

module hot_plug_status_function_regs #(
  parameter int DEGLITCH_CYCLES = hp_status_pkg::DEGLITCH_CYCLES
) (
  // Core clock and reset.
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // Serial register bus; the bus clock also clocks the link capture.
  input wire logic smb_clk_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // Address straps.
  input wire logic [2:0] addr_strap_i,
  // Slot inputs and outputs, index 0 is slot A.
  input wire hp_status_pkg::slot_in_t [1:0] slot_i,
  output hp_status_pkg::slot_out_t [1:0] slot_o,
  // Shared inputs.
  input wire logic [3:0] general_input_i,
  input wire logic thermal_shutdown_stage_one_i,
  input wire logic thermal_shutdown_stage_two_i,
  input wire logic undervoltage_lockout_i,
  // Interrupt, active low.
  output logic irq_n_o
);

  localparam int SLOT_W = $bits(hp_status_pkg::slot_in_t);
  localparam int SYNC_W = 2 * SLOT_W + 4 + 3 + 2 + 3;

  typedef struct packed {
    logic [SYNC_W-1:0] sync1;
    logic [SYNC_W-1:0] sync2;
    logic scl_prev;
    logic sda_prev;
    logic [1:0] strap_wait;
    logic strap_done;
    logic [2:0] addr;
    hp_status_pkg::bus_state_t st;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic rw;
    logic master_nack;
    logic [7:0] ptr;
    logic [7:0] txbyte;
    logic sda_oe;
    logic sda_out;
    logic [1:0][2:0] flag;
    logic [1:0][2:0] echo;
    logic [1:0][2:0] off_seen;
    logic uv;
    logic ot;
    logic echo_uv;
    logic echo_ot;
    logic mask;
    logic [1:0] fn_aux;
    logic [1:0] fn_main;
    logic [3:0][hp_status_pkg::DEGLITCH_CNT_W-1:0] gpi_cnt;
    logic [3:0] gpi_val;
    logic irq_n;
    hp_status_pkg::slot_out_t [1:0] sout;
  } state_t;

  typedef struct packed {
    logic bit_q;
  } link_state_t;

  state_t q;
  state_t d;
  link_state_t lq;

  // Link side: the data line is sampled on each rising bus clock edge.
  // The core reads it only after it has seen that edge through its own
  // synchroniser, so the sampled bit has been stable for several core cycles.
  always_ff @(posedge smb_clk_i) begin
    lq.bit_q <= sda_i;
  end

  // Synchronised views of the asynchronous inputs.
  logic [SYNC_W-1:0] raw_in;
  hp_status_pkg::slot_in_t [1:0] s_slot;
  logic [3:0] s_gpi;
  logic s_ts1;
  logic s_ts2;
  logic s_undervoltage_lockout;
  logic s_scl;
  logic s_sda;
  logic [2:0] s_strap;

  assign raw_in = {slot_i, general_input_i, thermal_shutdown_stage_one_i, thermal_shutdown_stage_two_i,
                   undervoltage_lockout_i, smb_clk_i, sda_i, addr_strap_i};
  assign {s_slot, s_gpi, s_ts1, s_ts2, s_undervoltage_lockout, s_scl, s_sda, s_strap} = q.sync2;

  // Deglitch of the general inputs.
  logic [3:0][hp_status_pkg::DEGLITCH_CNT_W-1:0] gpi_cnt_nx;
  logic [3:0] gpi_val_nx;
  localparam logic [hp_status_pkg::DEGLITCH_CNT_W-1:0] DEGLITCH_LAST =
    hp_status_pkg::DEGLITCH_CNT_W'(DEGLITCH_CYCLES - 1);

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_gpi
      always_comb begin
        gpi_cnt_nx[gi] = '0;
        gpi_val_nx[gi] = q.gpi_val[gi];
        if (s_gpi[gi] != q.gpi_val[gi]) begin
          if (q.gpi_cnt[gi] >= DEGLITCH_LAST) begin
            gpi_val_nx[gi] = s_gpi[gi];
          end else begin
            gpi_cnt_nx[gi] = q.gpi_cnt[gi] + 1'b1;
          end
        end
      end
    end
  endgenerate

  // Register read images.
  logic [1:0][7:0] rd_slot;
  logic [7:0] rd_shared;
  logic [7:0] rd_func;
  logic [1:0] discharged;

  always_comb begin
    for (int s = 0; s < 2; s++) begin
      discharged[s] = &s_slot[s].below_discharge;
      rd_slot[s] = '0;
      rd_slot[s][hp_status_pkg::SLOT_FAULT_MIRROR_BIT] = ~s_slot[s].smbus_mode & (|q.flag[s]);
      rd_slot[s][hp_status_pkg::MAIN_RAIL_ENABLED_BIT] = q.sout[s].main_rail_on;
      rd_slot[s][hp_status_pkg::STANDBY_RAIL_ENABLED_BIT] = q.sout[s].standby_rail_on;
      rd_slot[s][hp_status_pkg::STANDBY_OC_FLAG_BIT] = q.flag[s][hp_status_pkg::RAIL_STANDBY];
      rd_slot[s][hp_status_pkg::HIGH_RAIL_OC_FLAG_BIT] = q.flag[s][hp_status_pkg::RAIL_HIGH];
      rd_slot[s][hp_status_pkg::LOW_RAIL_OC_FLAG_BIT] = q.flag[s][hp_status_pkg::RAIL_LOW];
    end
    rd_shared = '0;
    rd_shared[hp_status_pkg::GENERAL_INPUT_LSB +: 4] = q.gpi_val;
    rd_shared[hp_status_pkg::IRQ_OUTPUT_MASK_BIT] = q.mask;
    rd_shared[hp_status_pkg::UNDERVOLTAGE_FLAG_BIT] = q.uv;
    rd_shared[hp_status_pkg::OVERTEMPERATURE_FLAG_BIT] = q.ot;
    rd_func = '0;
    rd_func[hp_status_pkg::STANDBY_LIMIT_SELECT_LSB +: 2] = q.fn_aux;
    rd_func[hp_status_pkg::SLOT_DISCHARGED_LSB +: 2] = discharged;
    rd_func[hp_status_pkg::MAIN_LIMIT_ENABLE_LSB +: 2] = q.fn_main;
    rd_func[hp_status_pkg::MAKER_IDENTITY_BIT] = hp_status_pkg::MAKER_IDENTITY_VALUE;
  end

  function automatic logic [7:0] reg_image(input logic [7:0] a, input logic [1:0][7:0] sl,
                                           input logic [7:0] sh, input logic [7:0] fn);
    logic [7:0] v;
    v = '0;
    unique case (a)
      hp_status_pkg::SLOT_A_FAULT_STATUS_OFS: v = sl[0];
      hp_status_pkg::SLOT_B_FAULT_STATUS_OFS: v = sl[1];
      hp_status_pkg::SHARED_STATUS_OFS: v = sh;
      hp_status_pkg::SPECIAL_FUNCTION_CTL_OFS: v = fn;
      default: v = '0;
    endcase
    return v;
  endfunction

  // Bus events seen through the synchroniser.
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  assign scl_rise = s_scl & ~q.scl_prev;
  assign scl_fall = ~s_scl & q.scl_prev;
  assign bus_start = s_scl & q.scl_prev & q.sda_prev & ~s_sda;
  assign bus_stop = s_scl & q.scl_prev & ~q.sda_prev & s_sda;

  always_comb begin
    logic wr_en;
    logic rd_en;
    logic [7:0] load;
    logic cond;
    logic en;
    logic clr;
    logic main_any;
    logic smb_any;
    logic rd_hit;
    logic any_fault;
    int bp;
    wr_en = 1'b0;
    rd_en = 1'b0;
    load = '0;
    cond = 1'b0;
    en = 1'b0;
    clr = 1'b0;
    rd_hit = 1'b0;
    bp = 0;
    main_any = 1'b0;
    smb_any = 1'b0;
    any_fault = 1'b0;
    d = q;
    d.sync1 = raw_in;
    d.sync2 = q.sync1;
    d.scl_prev = s_scl;
    d.sda_prev = s_sda;
    d.gpi_cnt = gpi_cnt_nx;
    d.gpi_val = gpi_val_nx;
    d.sda_out = 1'b0;

    // Address straps are caught once the synchroniser has filled.
    if (!q.strap_done) begin
      if (q.strap_wait == 2'(hp_status_pkg::STRAP_SETTLE_CYCLES - 1)) begin
        d.addr = s_strap;
        d.strap_done = 1'b1;
      end else begin
        d.strap_wait = q.strap_wait + 1'b1;
      end
    end

    // Serial target state machine.
    if (scl_rise && (q.st != hp_status_pkg::ST_IDLE)) begin
      d.bitcnt = q.bitcnt + 1'b1;
      d.shreg = {q.shreg[6:0], lq.bit_q};
      if (q.st == hp_status_pkg::ST_ACK_RDATA) begin
        d.master_nack = lq.bit_q;
      end
    end
    if (bus_start) begin
      d.st = hp_status_pkg::ST_ADDR;
      d.bitcnt = '0;
      d.sda_oe = 1'b0;
    end else if (bus_stop) begin
      d.st = hp_status_pkg::ST_IDLE;
      d.sda_oe = 1'b0;
    end else if (scl_fall) begin
      unique case (q.st)
        hp_status_pkg::ST_IDLE: begin
          d.sda_oe = 1'b0;
        end
        hp_status_pkg::ST_ADDR: begin
          if (q.bitcnt == 4'd8) begin
            d.bitcnt = '0;
            if (q.shreg[7:1] == {hp_status_pkg::TARGET_ADDR_UPPER, q.addr}) begin
              d.rw = q.shreg[0];
              d.sda_oe = 1'b1;
              d.st = hp_status_pkg::ST_ACK_ADDR;
            end else begin
              d.st = hp_status_pkg::ST_IDLE;
            end
          end
        end
        hp_status_pkg::ST_CMD, hp_status_pkg::ST_WDATA: begin
          if (q.bitcnt == 4'd8) begin
            d.bitcnt = '0;
            d.sda_oe = 1'b1;
            if (q.st == hp_status_pkg::ST_CMD) begin
              d.ptr = q.shreg;
              d.st = hp_status_pkg::ST_ACK_CMD;
            end else begin
              wr_en = 1'b1;
              d.st = hp_status_pkg::ST_ACK_WDATA;
            end
          end
        end
        hp_status_pkg::ST_ACK_CMD, hp_status_pkg::ST_ACK_WDATA: begin
          d.bitcnt = '0;
          d.sda_oe = 1'b0;
          d.st = hp_status_pkg::ST_WDATA;
        end
        hp_status_pkg::ST_ACK_ADDR, hp_status_pkg::ST_ACK_RDATA: begin
          d.bitcnt = '0;
          if (q.st == hp_status_pkg::ST_ACK_ADDR && !q.rw) begin
            d.sda_oe = 1'b0;
            d.st = hp_status_pkg::ST_CMD;
          end else if (q.st == hp_status_pkg::ST_ACK_RDATA && q.master_nack) begin
            d.sda_oe = 1'b0;
            d.st = hp_status_pkg::ST_IDLE;
          end else begin
            rd_en = 1'b1;
            load = reg_image(q.ptr, rd_slot, rd_shared, rd_func);
            d.txbyte = load;
            d.sda_oe = ~load[7];
            d.st = hp_status_pkg::ST_RDATA;
          end
        end
        hp_status_pkg::ST_RDATA: begin
          if (q.bitcnt == 4'd8) begin
            d.sda_oe = 1'b0;
            d.bitcnt = '0;
            d.st = hp_status_pkg::ST_ACK_RDATA;
          end else begin
            d.sda_oe = ~q.txbyte[3'(4'd7 - q.bitcnt)];
          end
        end
        default: begin
          d.st = hp_status_pkg::ST_IDLE;
          d.sda_oe = 1'b0;
        end
      endcase
    end

    // Slot overcurrent flags with echo reset.
    for (int s = 0; s < 2; s++) begin
      rd_hit = rd_en && (q.ptr == (s == 0 ? hp_status_pkg::SLOT_A_FAULT_STATUS_OFS
                                          : hp_status_pkg::SLOT_B_FAULT_STATUS_OFS));
      for (int r = 0; r < 3; r++) begin
        bp = (r == hp_status_pkg::RAIL_STANDBY) ? hp_status_pkg::STANDBY_OC_FLAG_BIT :
             (r == hp_status_pkg::RAIL_HIGH) ? hp_status_pkg::HIGH_RAIL_OC_FLAG_BIT :
             hp_status_pkg::LOW_RAIL_OC_FLAG_BIT;
        cond = s_slot[s].overcurrent[r] & (s_slot[s].oc_timer_expired[r] | s_ts1);
        if (r != hp_status_pkg::RAIL_STANDBY) begin
          cond = cond | s_slot[s].fast_trip[r];
        end
        en = (r == hp_status_pkg::RAIL_STANDBY) ? s_slot[s].aux_req : s_slot[s].main_req;
        clr = q.flag[s][r] & ~cond & q.off_seen[s][r] & en &
              (~s_slot[s].smbus_mode | (q.echo[s][r] & rd_hit));
        d.flag[s][r] = cond | (q.flag[s][r] & ~clr);
        d.off_seen[s][r] = ~en | (q.off_seen[s][r] & ~cond);
        if (clr || !q.flag[s][r]) begin
          d.echo[s][r] = 1'b0;
        end
        if (wr_en && rd_hit == 1'b0 && q.ptr == (s == 0 ? hp_status_pkg::SLOT_A_FAULT_STATUS_OFS
                                                        : hp_status_pkg::SLOT_B_FAULT_STATUS_OFS)
            && q.shreg[bp] && q.flag[s][r]) begin
          d.echo[s][r] = 1'b1;
        end
      end
    end

    // Shared status flags.
    main_any = s_slot[0].main_req | s_slot[1].main_req;
    smb_any = s_slot[0].smbus_mode | s_slot[1].smbus_mode;
    rd_hit = rd_en && (q.ptr == hp_status_pkg::SHARED_STATUS_OFS);
    clr = ~main_any | (~s_undervoltage_lockout & (~smb_any | (q.echo_uv & rd_hit)));
    d.uv = (s_undervoltage_lockout & main_any) | (q.uv & ~clr);
    if (clr || !q.uv) begin
      d.echo_uv = 1'b0;
    end
    clr = ~s_ts2 & (~smb_any | (q.echo_ot & rd_hit));
    d.ot = s_ts2 | (q.ot & ~clr);
    if (clr || !q.ot) begin
      d.echo_ot = 1'b0;
    end
    if (wr_en && q.ptr == hp_status_pkg::SHARED_STATUS_OFS) begin
      d.mask = q.shreg[hp_status_pkg::IRQ_OUTPUT_MASK_BIT];
      if (q.shreg[hp_status_pkg::UNDERVOLTAGE_FLAG_BIT] && q.uv) begin
        d.echo_uv = 1'b1;
      end
      if (q.shreg[hp_status_pkg::OVERTEMPERATURE_FLAG_BIT] && q.ot) begin
        d.echo_ot = 1'b1;
      end
    end
    if (wr_en && q.ptr == hp_status_pkg::SPECIAL_FUNCTION_CTL_OFS) begin
      d.fn_aux = q.shreg[hp_status_pkg::STANDBY_LIMIT_SELECT_LSB +: 2];
      d.fn_main = q.shreg[hp_status_pkg::MAIN_LIMIT_ENABLE_LSB +: 2];
    end

    // Slot outputs.
    for (int s = 0; s < 2; s++) begin
      d.sout[s].main_rail_on = s_slot[s].main_req & s_slot[s].force_on_input & ~s_undervoltage_lockout & ~s_ts2 &
                               ~q.flag[s][hp_status_pkg::RAIL_HIGH] & ~q.flag[s][hp_status_pkg::RAIL_LOW];
      d.sout[s].standby_rail_on = s_slot[s].aux_req & ~s_ts2 & ~q.flag[s][hp_status_pkg::RAIL_STANDBY];
      d.sout[s].fault_pin_oe = (|q.flag[s]) & s_slot[s].force_on_input;
      d.sout[s].standby_high_mode = s_slot[s].standby_high_strap_pin | q.fn_aux[s];
      d.sout[s].main_limit_enable = q.fn_main[s];
    end

    any_fault = (|q.flag) | q.uv | q.ot;
    d.irq_n = ~(~q.mask & any_fault);
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      q <= '0;
      q.st <= hp_status_pkg::ST_IDLE;
      q.scl_prev <= 1'b1;
      q.sda_prev <= 1'b1;
      q.off_seen <= '1;
      q.fn_aux <= hp_status_pkg::SPECIAL_FUNCTION_RESET[hp_status_pkg::STANDBY_LIMIT_SELECT_LSB +: 2];
      q.fn_main <= hp_status_pkg::SPECIAL_FUNCTION_RESET[hp_status_pkg::MAIN_LIMIT_ENABLE_LSB +: 2];
      q.mask <= hp_status_pkg::SHARED_STATUS_RESET[hp_status_pkg::IRQ_OUTPUT_MASK_BIT];
      q.irq_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign sda_o = q.sda_out;
  assign sda_oe_o = q.sda_oe;
  assign slot_o = q.sout;
  assign irq_n_o = q.irq_n;

endmodule

`default_nettype wire

// File: design/hp_status_pkg.sv
// Constants, field layouts and carrier types of the hot plug status register block.
`default_nettype none

package hp_status_pkg;

  // Register offsets on the serial register bus.
  localparam logic [7:0] SLOT_A_FAULT_STATUS_OFS = 8'h04;
  localparam logic [7:0] SLOT_B_FAULT_STATUS_OFS = 8'h05;
  localparam logic [7:0] SHARED_STATUS_OFS = 8'h06;
  localparam logic [7:0] SPECIAL_FUNCTION_CTL_OFS = 8'h07;

  // Reset values.
  localparam logic [7:0] SLOT_STATUS_RESET = 8'h00;
  localparam logic [7:0] SHARED_STATUS_RESET = 8'h00;
  localparam logic [7:0] SPECIAL_FUNCTION_RESET = 8'h0d;

  // Slot status field positions.
  localparam int SLOT_FAULT_MIRROR_BIT = 7;
  localparam int MAIN_RAIL_ENABLED_BIT = 6;
  localparam int STANDBY_RAIL_ENABLED_BIT = 5;
  localparam int STANDBY_OC_FLAG_BIT = 4;
  localparam int HIGH_RAIL_OC_FLAG_BIT = 2;
  localparam int LOW_RAIL_OC_FLAG_BIT = 0;

  // Shared status field positions.
  localparam int GENERAL_INPUT_LSB = 4;
  localparam int IRQ_OUTPUT_MASK_BIT = 3;
  localparam int UNDERVOLTAGE_FLAG_BIT = 2;
  localparam int OVERTEMPERATURE_FLAG_BIT = 1;

  // Special function field positions.
  localparam int STANDBY_LIMIT_SELECT_LSB = 6;
  localparam int SLOT_DISCHARGED_LSB = 4;
  localparam int MAIN_LIMIT_ENABLE_LSB = 2;
  localparam int MAKER_IDENTITY_BIT = 0;
  // Arbitrary neutral value for the identity bit position content.
  localparam logic MAKER_IDENTITY_VALUE = 1'b1;

  // Target address: fixed upper bits, lower bits from straps.
  localparam logic [3:0] TARGET_ADDR_UPPER = 4'h8;

  // Rail index inside a slot.
  localparam int RAIL_LOW = 0;
  localparam int RAIL_HIGH = 1;
  localparam int RAIL_STANDBY = 2;

  // Timing.
  localparam longint CORE_CLK_HZ = 40_000_000;
  localparam longint DEGLITCH_TIME_MS = 5;
  localparam int DEGLITCH_CYCLES = int'((DEGLITCH_TIME_MS * CORE_CLK_HZ) / 1000);
  localparam int DEGLITCH_CNT_W = 18;
  localparam int STRAP_SETTLE_CYCLES = 3;

  // Per-slot pin and comparator inputs.
  typedef struct packed {
    logic main_req;
    logic aux_req;
    logic smbus_mode;
    logic force_on_input;
    logic [2:0] overcurrent;
    logic [2:0] oc_timer_expired;
    logic [1:0] fast_trip;
    logic [2:0] below_discharge;
    logic standby_high_strap_pin;
  } slot_in_t;

  // Per-slot outputs.
  typedef struct packed {
    logic fault_pin_oe;
    logic main_rail_on;
    logic standby_rail_on;
    logic standby_high_mode;
    logic main_limit_enable;
  } slot_out_t;

  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ACK_ADDR, ST_CMD, ST_ACK_CMD,
    ST_WDATA, ST_ACK_WDATA, ST_RDATA, ST_ACK_RDATA
  } bus_state_t;

endpackage

`default_nettype wire

// File: tb/hot_plug_status_function_regs_tb.sv
// Top-level testbench of the hot plug status and function register block.
`default_nettype none

module hot_plug_status_function_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic [2:0] strap = 3'h5;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic scl, host_pull, sda_o, sda_oe, irq_n, ts1, ts2, uvl, ack;
  wire sda_line;
  hp_status_pkg::slot_in_t [1:0] slot_v;
  hp_status_pkg::slot_out_t [1:0] slot_o;
  logic [3:0] gpi;
  int bad_count = 0;
  int n_compared = 0;
  int cycles = 0;

  assign sda_line = ~host_pull & (~sda_oe | sda_o);
  always #12.5 core_clk = ~core_clk;

  hot_plug_status_function_regs #(.DEGLITCH_CYCLES(16)) i_hot_plug_status_function_regs (
    .core_clk_i(core_clk), .sys_rst_i(sys_rst), .smb_clk_i(scl), .sda_i(sda_line), .sda_o(sda_o),
    .sda_oe_o(sda_oe), .addr_strap_i(strap), .slot_i(slot_v), .slot_o(slot_o), .general_input_i(gpi),
    .thermal_shutdown_stage_one_i(ts1), .thermal_shutdown_stage_two_i(ts2),
    .undervoltage_lockout_i(uvl), .irq_n_o(irq_n));

  smb_host_model i_smb_host_model (.scl_o(scl), .sda_pull_o(host_pull), .sda_i(sda_line));

  task automatic end_sim();
    $display("Compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    chk({7'h00, got}, {7'h00, exp});
  endtask

  task automatic settle(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  task automatic wr(input logic [7:0] ofs, input logic [7:0] dat);
    i_smb_host_model.write_reg(ofs, dat, strap, ack);
    chk1(ack, 1'b1);
    settle(2);
  endtask

  task automatic rd(input logic [7:0] ofs, input logic [7:0] exp);
    logic [7:0] d;
    i_smb_host_model.read_reg(ofs, strap, d, ack);
    chk1(ack, 1'b1);
    chk(d, exp);
    settle(2);
  endtask

  task automatic set_slot(input int s, input logic m, input logic a, input logic sm, input logic f);
    settle(1);
    slot_v[s].main_req = m;
    slot_v[s].aux_req = a;
    slot_v[s].smbus_mode = sm;
    slot_v[s].force_on_input = f;
    settle(8);
  endtask

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 60000) begin
      bad_count++;
      $display("BAD %0t run did not finish", $time);
      end_sim();
    end
  end

  initial begin
    slot_v = '0;
    gpi = 4'h0;
    ts1 = 1'b0;
    ts2 = 1'b0;
    uvl = 1'b0;
    settle(10);
    sys_rst = 1'b0;
    settle(10);
    // Reset values, unmapped offset and a foreign address.
    rd(8'h04, 8'h00);
    rd(8'h05, 8'h00);
    rd(8'h06, 8'h00);
    rd(8'h07, 8'h0d);
    wr(8'h01, 8'h55);
    rd(8'h01, 8'h00);
    i_smb_host_model.write_reg(8'h07, 8'h01, ~strap, ack);
    chk1(ack, 1'b0);
    rd(8'h07, 8'h0d);
    // Slot A under bus control: fast trip, then echo clear.
    set_slot(0, 1'b1, 1'b1, 1'b1, 1'b1);
    rd(8'h04, 8'h60);
    slot_v[0].fast_trip[1] = 1'b1;
    settle(8);
    slot_v[0].fast_trip[1] = 1'b0;
    settle(8);
    chk1(irq_n, 1'b0);
    rd(8'h04, 8'h24);
    set_slot(0, 1'b0, 1'b1, 1'b1, 1'b1);
    set_slot(0, 1'b1, 1'b1, 1'b1, 1'b1);
    wr(8'h04, 8'h04);
    rd(8'h04, 8'h24);
    rd(8'h04, 8'h60);
    chk1(irq_n, 1'b1);
    // Masked overtemperature, then echo clear with the mask lifted.
    wr(8'h06, 8'h08);
    ts2 = 1'b1;
    settle(8);
    rd(8'h06, 8'h0a);
    chk1(irq_n, 1'b1);
    ts2 = 1'b0;
    set_slot(0, 1'b0, 1'b1, 1'b1, 1'b1);
    set_slot(0, 1'b1, 1'b1, 1'b1, 1'b1);
    wr(8'h06, 8'h02);
    chk1(irq_n, 1'b0);
    rd(8'h06, 8'h02);
    rd(8'h06, 8'h00);
    chk1(irq_n, 1'b1);
    // Undervoltage seen only while main rails are requested.
    uvl = 1'b1;
    settle(8);
    rd(8'h06, 8'h04);
    set_slot(0, 1'b0, 1'b1, 1'b1, 1'b1);
    rd(8'h06, 8'h00);
    uvl = 1'b0;
    // General inputs: a short glitch is ignored, a steady level is reported.
    gpi = 4'hf;
    settle(8);
    gpi = 4'h0;
    settle(40);
    rd(8'h06, 8'h00);
    gpi = 4'ha;
    settle(40);
    rd(8'h06, 8'ha0);
    // Function register, discharge flags and strap override.
    slot_v[0].below_discharge = 3'b111;
    slot_v[1].below_discharge = 3'b011;
    wr(8'h07, 8'hc1);
    rd(8'h07, 8'hd1);
    chk1(slot_o[0].standby_high_mode, 1'b1);
    chk1(slot_o[1].main_limit_enable, 1'b0);
    wr(8'h07, 8'h0d);
    slot_v[0].standby_high_strap_pin = 1'b1;
    settle(8);
    rd(8'h07, 8'h1d);
    chk1(slot_o[0].standby_high_mode, 1'b1);
    chk1(slot_o[1].standby_high_mode, 1'b0);
    chk1(slot_o[0].main_limit_enable, 1'b1);
    // Slot B in direct mode: fault pin, force release and flag causes.
    set_slot(1, 1'b1, 1'b1, 1'b0, 1'b1);
    slot_v[1].fast_trip[0] = 1'b1;
    settle(8);
    slot_v[1].fast_trip[0] = 1'b0;
    settle(8);
    chk1(slot_o[1].fault_pin_oe, 1'b1);
    rd(8'h05, 8'ha1);
    set_slot(1, 1'b1, 1'b1, 1'b0, 1'b0);
    chk1(slot_o[1].fault_pin_oe, 1'b0);
    rd(8'h05, 8'ha1);
    slot_v[1].overcurrent = 3'b110;
    slot_v[1].oc_timer_expired = 3'b100;
    ts1 = 1'b1;
    settle(8);
    slot_v[1].overcurrent = 3'b000;
    slot_v[1].oc_timer_expired = 3'b000;
    ts1 = 1'b0;
    settle(8);
    rd(8'h05, 8'h95);
    set_slot(1, 1'b0, 1'b0, 1'b0, 1'b0);
    set_slot(1, 1'b1, 1'b1, 1'b0, 1'b0);
    rd(8'h05, 8'h20);
    // Second reset with other straps: the new address answers, the old one is ignored.
    sys_rst = 1'b1;
    strap = 3'h2;
    settle(10);
    sys_rst = 1'b0;
    settle(10);
    rd(8'h07, 8'h1d);
    i_smb_host_model.write_reg(8'h07, 8'h01, 3'h5, ack);
    chk1(ack, 1'b0);
    end_sim();
  end
endmodule

bind hot_plug_status_function_regs hp_status_chk #(.DEGLITCH_CYCLES(DEGLITCH_CYCLES)) i_hp_status_chk (
  .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .smb_clk_i(smb_clk_i), .sda_oe_o(sda_oe_o),
  .slot_i(slot_i), .slot_o(slot_o), .irq_n_o(irq_n_o));

`default_nettype wire

// File: tb/hp_status_chk.sv
// Concurrent checks on the ports of the hot plug status register block.
`default_nettype none

module hp_status_chk #(
  parameter int DEGLITCH_CYCLES = 16
) (
  // Clock and reset.
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // Serial bus.
  input wire logic smb_clk_i,
  input wire logic sda_oe_o,
  // Slots and interrupt.
  input wire hp_status_pkg::slot_in_t [1:0] slot_i,
  input wire hp_status_pkg::slot_out_t [1:0] slot_o,
  input wire logic irq_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);

  // Serial clock seen high on two samples in a row.
  sequence s_scl_high_held;
    smb_clk_i [*2];
  endsequence
  // Main request of slot A absent long enough to pass the synchronisers.
  sequence s_main_req_off;
    !slot_i[0].main_req [*6];
  endsequence

  property p_rst_quiet;
    $fell(sys_rst_i) |-> irq_n_o && !sda_oe_o && (slot_o == '0);
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("Outputs not quiet after reset.");
  property p_strap_high;
    slot_i[0].standby_high_strap_pin [*6] |-> slot_o[0].standby_high_mode;
  endproperty
  a_strap_high: assert property (p_strap_high) else $error("Strap did not force high mode.");
  property p_strap_sync;
    $rose(slot_i[0].standby_high_strap_pin) && !slot_o[0].standby_high_mode |-> !slot_o[0].standby_high_mode [*2];
  endproperty
  a_strap_sync: assert property (p_strap_sync) else $error("Strap used before synchronising.");
  property p_main_off;
    s_main_req_off |-> !slot_o[0].main_rail_on;
  endproperty
  a_main_off: assert property (p_main_off) else $error("Main rail on without request.");
  property p_aux_off;
    !slot_i[1].aux_req [*6] |-> !slot_o[1].standby_rail_on;
  endproperty
  a_aux_off: assert property (p_aux_off) else $error("Standby rail on without request.");
  property p_force_pin;
    !slot_i[1].force_on_input [*6] |-> !slot_o[1].fault_pin_oe;
  endproperty
  a_force_pin: assert property (p_force_pin) else $error("Fault pin driven with force low.");
  property p_trip_main;
    slot_i[1].fast_trip[0] [*6] |-> !slot_o[1].main_rail_on;
  endproperty
  a_trip_main: assert property (p_trip_main) else $error("Main rail on during fast trip.");
  property p_sda_steady;
    s_scl_high_held |-> $stable(sda_oe_o);
  endproperty
  a_sda_steady: assert property (p_sda_steady) else $error("Data changed while clock high.");
  property p_sda_low_phase;
    $changed(sda_oe_o) |-> !smb_clk_i;
  endproperty
  a_sda_low_phase: assert property (p_sda_low_phase) else $error("Data moved outside low phase.");
endmodule

`default_nettype wire

// File: tb/smb_host_model.sv
// Serial bus host model that frames register reads and writes.
`default_nettype none

module smb_host_model (
  // Serial bus lines.
  output logic scl_o,
  output logic sda_pull_o,
  input wire logic sda_i
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    scl_o = 1'b1;
    sda_pull_o = 1'b0;
  end

  // One tick is 30 ns; each clock phase lasts eight ticks.
  task automatic tick(input int n);
    #(30 * n);
  endtask

  task automatic put_bit(input logic b, output logic got);
    sda_pull_o = ~b;
    tick(4);
    scl_o = 1'b1;
    tick(4);
    got = sda_i;
    tick(4);
    scl_o = 1'b0;
    tick(4);
  endtask

  task automatic put_byte(input logic [7:0] v, output logic ack);
    logic g;
    for (int i = 7; i >= 0; i--) begin
      put_bit(v[i], g);
    end
    put_bit(1'b1, g);
    ack = ~g;
  endtask

  task automatic start_cond();
    sda_pull_o = 1'b0;
    tick(4);
    scl_o = 1'b1;
    tick(4);
    sda_pull_o = 1'b1;
    tick(4);
    scl_o = 1'b0;
    tick(4);
  endtask

  task automatic stop_cond();
    sda_pull_o = 1'b1;
    tick(4);
    scl_o = 1'b1;
    tick(4);
    sda_pull_o = 1'b0;
    tick(8);
  endtask

  task automatic write_reg(input logic [7:0] ofs, input logic [7:0] dat, input logic [2:0] adr, output logic ack);
    logic a1, a2, a3;
    start_cond();
    put_byte({hp_status_pkg::TARGET_ADDR_UPPER, adr, 1'b0}, a1);
    put_byte(ofs, a2);
    put_byte(dat, a3);
    stop_cond();
    ack = a1 & a2 & a3;
  endtask

  task automatic read_reg(input logic [7:0] ofs, input logic [2:0] adr, output logic [7:0] dat, output logic ack);
    logic a1, a2, a3, g;
    start_cond();
    put_byte({hp_status_pkg::TARGET_ADDR_UPPER, adr, 1'b0}, a1);
    put_byte(ofs, a2);
    start_cond();
    put_byte({hp_status_pkg::TARGET_ADDR_UPPER, adr, 1'b1}, a3);
    for (int i = 7; i >= 0; i--) begin
      put_bit(1'b1, dat[i]);
    end
    put_bit(1'b1, g);
    stop_cond();
    ack = a1 & a2 & a3;
  endtask
endmodule

`default_nettype wire
